// ==== design/buf_base_defines.svh ====
// constants of the buffer base state command and of the issuing controller
// assumes inclusion by bare name from every design file that needs them
`ifndef BUF_BASE_DEFINES_SVH
`define BUF_BASE_DEFINES_SVH

// header fields of dword 0
`define HDR_TYPE_HI       31
`define HDR_TYPE_LO       29
`define HDR_TYPE_VAL      3'h3
`define HDR_PIPE_HI       28
`define HDR_PIPE_LO       27
`define HDR_PIPE_VAL      2'h2
`define HDR_OPC_HI        26
`define HDR_OPC_LO        24
`define HDR_OPC_VAL       3'h4
`define HDR_SUB_HI        23
`define HDR_SUB_LO        16
`define HDR_SUB_VAL       8'h03
`define HDR_LEN_HI        15
`define HDR_LEN_LO        0
`define HDR_LEN_VAL       16'h0048

// payload dword positions
`define DW_STREAM_ROW     7'h01
`define DW_MVP_ROW        7'h02
`define DW_MB_INFO        7'h03
`define DW_IT_DATA        7'h04
`define DW_DEBLOCK        7'h05
`define DW_COL_RD_FIRST   7'h06
`define DW_COL_RD_LAST    7'h25
`define DW_COL_WR_TOP     7'h26
`define DW_COL_WR_BOT     7'h27
`define DW_POC_FIRST      7'h28
`define DW_POC_LAST       7'h49

// address field positions
`define ADDR_HI           31
`define ADDR_LO           6
`define IT_BASE_LO        12
`define IT_OFF_HI         11

// layout of the working buffers in bytes per macroblock, row width in macroblocks, store selectors and POC entry count
`define STREAM_ROW_MBAFF  32'd96
`define STREAM_ROW_PLAIN  32'd48
`define MVP_ROW_MBAFF     32'd64
`define MVP_ROW_PLAIN     32'd32
`define MB_INFO_BYTES     32'd64
`define DEBLOCK_BYTES     32'd128
`define COL_MV_BYTES      32'd64
`define COL_ROW_MBS       32'd128
`define IT_SLOT_BYTES     32'd2048
`define STORE_SEL_SHARED  5'h0f
`define STORE_SEL_OWN     5'h10
`define POC_ENTRIES       6'h22

// controller registers, byte addresses
`define REG_CTRL          12'h000
`define REG_STATUS        12'h004
`define REG_PAYLOAD       12'h100
`define CTRL_GO_BIT       0
`define STAT_BUSY_BIT     0
`define STAT_DONE_BIT     1

`endif

// ==== design/buf_base_pkg.sv ====
// types shared by both ends of the buffer base state link
// assumes buf_base_defines.svh for the numeric constants
package buf_base_pkg;
	typedef logic [31:0] dword_t;
	typedef logic [25:0] cl_addr_t;
	typedef logic [6:0]  dw_idx_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LOAD = 2'b01,
		ST_SKIP = 2'b11
	} parse_state_t;
	typedef enum logic {
		TX_IDLE = 1'b0,
		TX_SEND = 1'b1
	} send_state_t;
endpackage

// ==== design/buf_base_if.sv ====
// dword stream from the command issuer to the state store
// assumes both ends run on the same clock, supplied outside
`timescale 1ns/1ps
interface buf_base_if;
	logic                  dw_valid;
	buf_base_pkg::dword_t  dw_data;
	logic                  dw_ready;

	modport issuer (
		output dw_valid,
		output dw_data,
		input  dw_ready
	);
	modport store (
		input  dw_valid,
		input  dw_data,
		output dw_ready
	);
endinterface

// ==== design/cmd_header_check.sv ====
// combinational check of a command header dword
// assumes the caller samples the result only on a header dword
`timescale 1ns/1ps
`include "buf_base_defines.svh"
module cmd_header_check (
	// header under test
	input  wire buf_base_pkg::dword_t hdr,
	// verdict
	output logic                      hit,
	output logic [15:0]               length
);
	import buf_base_pkg::*;

	always_comb begin
		length = hdr[`HDR_LEN_HI:`HDR_LEN_LO];
		hit    = (hdr[`HDR_TYPE_HI:`HDR_TYPE_LO] == `HDR_TYPE_VAL)
		      && (hdr[`HDR_PIPE_HI:`HDR_PIPE_LO] == `HDR_PIPE_VAL)
		      && (hdr[`HDR_OPC_HI:`HDR_OPC_LO] == `HDR_OPC_VAL)
		      && (hdr[`HDR_SUB_HI:`HDR_SUB_LO] == `HDR_SUB_VAL)
		      && (hdr[`HDR_LEN_HI:`HDR_LEN_LO] == `HDR_LEN_VAL);
	end
endmodule // cmd_header_check

// ==== design/base_state_store.sv ====
// state store end: parses the buffer base state command, holds the bases
// assumes one clock with the issuer; the decoder queries addresses beside it
//
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`include "buf_base_defines.svh"
module base_state_store #(
	parameter int unsigned SLOT_BYTES = 2048
) (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	// command dwords from the issuer
	buf_base_if.store                     cmd,
	// decoder queries
	input  wire logic [6:0]               mb_x,
	input  wire logic [7:0]               mb_y,
	input  wire logic [13:0]              mb_num,
	input  wire logic                     mbaff,
	input  wire logic [4:0]               col_ref_idx,
	input  wire logic [4:0]               current_store_selector,
	input  wire logic                     bottom_field,
	input  wire logic [5:0]               frame_store_index,
	input  wire logic                     poc_bottom,
	// addresses and values for the decoder
	output buf_base_pkg::dword_t          stream_row_addr_r,
	output buf_base_pkg::dword_t          mvp_row_addr_r,
	output buf_base_pkg::dword_t          mb_info_addr_r,
	output buf_base_pkg::dword_t          it_data_addr_r,
	output buf_base_pkg::dword_t          it_indirect_start_r,
	output buf_base_pkg::dword_t          deblock_addr_r,
	output buf_base_pkg::dword_t          col_rd_addr_r,
	output buf_base_pkg::dword_t          col_wr_addr_r,
	output logic                          col_wr_valid_r,
	output buf_base_pkg::dword_t          poc_value_r,
	// command status
	output logic                          state_loaded_r,
	output logic                          load_done_r,
	output logic                          hdr_error_r
);
	import buf_base_pkg::*;

	if (SLOT_BYTES < 64 || SLOT_BYTES % 64 != 0) begin : g_slot_check
		$error("SLOT_BYTES must be a non-zero multiple of 64");
	end

	parse_state_t state_r;
	dw_idx_t      idx_r;
	logic [15:0]  remain_r;
	logic         take;
	logic         hdr_hit;
	logic [15:0]  hdr_len;
	logic         dw_ready_r;

	cl_addr_t     stream_row_r;
	cl_addr_t     mvp_row_r;
	cl_addr_t     mb_info_r;
	logic [19:0]  it_base_r;
	logic [5:0]   it_off_r;
	cl_addr_t     deblock_r;
	cl_addr_t     col_wr_top_r;
	cl_addr_t     col_wr_bot_r;
	cl_addr_t     col_rd_r [32];
	dword_t       poc_r [34];

	assign cmd.dw_ready = dw_ready_r;
	assign take         = cmd.dw_valid && dw_ready_r;

	cmd_header_check u_hdr (
		.hdr    (cmd.dw_data),
		.hit    (hdr_hit),
		.length (hdr_len)
	);

	// never stalls the issuer: every dword is taken the cycle it is offered
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			dw_ready_r <= 1'b0;
		else
			dw_ready_r <= 1'b1;
	end

	// a foreign or malformed command is skipped by its own length field
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r  <= ST_IDLE;
			idx_r    <= '0;
			remain_r <= '0;
		end else if (take) begin
			unique case (state_r)
				ST_IDLE: begin
					idx_r    <= `DW_STREAM_ROW;
					remain_r <= hdr_len + 16'h0001;
					if (hdr_hit)
						state_r <= ST_LOAD;
					else
						state_r <= ST_SKIP;
				end
				ST_LOAD: begin
					idx_r <= idx_r + 7'h01;
					if (idx_r == `DW_POC_LAST)
						state_r <= ST_IDLE;
				end
				ST_SKIP: begin
					remain_r <= remain_r - 16'h0001;
					if (remain_r == 16'h0001)
						state_r <= ST_IDLE;
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			load_done_r    <= 1'b0;
			hdr_error_r    <= 1'b0;
			state_loaded_r <= 1'b0;
		end else begin
			load_done_r <= take && state_r == ST_LOAD && idx_r == `DW_POC_LAST;
			hdr_error_r <= take && state_r == ST_IDLE && !hdr_hit;
			if (take && state_r == ST_LOAD && idx_r == `DW_POC_LAST)
				state_loaded_r <= 1'b1;
		end
	end

	// fields change only on a payload dword of a matching command
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stream_row_r <= '0;
			mvp_row_r    <= '0;
			mb_info_r    <= '0;
			it_base_r    <= '0;
			it_off_r     <= '0;
			deblock_r    <= '0;
			col_wr_top_r <= '0;
			col_wr_bot_r <= '0;
			for (int i = 0; i < 32; i++)
				col_rd_r[i] <= '0;
			for (int i = 0; i < 34; i++)
				poc_r[i] <= '0;
		end else if (take && state_r == ST_LOAD) begin
			// reserved low six bits of address dwords are dropped; POC dwords are stored whole
			if (idx_r == `DW_STREAM_ROW)
				stream_row_r <= cmd.dw_data[`ADDR_HI:`ADDR_LO];
			if (idx_r == `DW_MVP_ROW)
				mvp_row_r <= cmd.dw_data[`ADDR_HI:`ADDR_LO];
			if (idx_r == `DW_MB_INFO)
				mb_info_r <= cmd.dw_data[`ADDR_HI:`ADDR_LO];
			if (idx_r == `DW_IT_DATA) begin
				it_base_r <= cmd.dw_data[`ADDR_HI:`IT_BASE_LO];
				it_off_r  <= cmd.dw_data[`IT_OFF_HI:`ADDR_LO];
			end
			if (idx_r == `DW_DEBLOCK)
				deblock_r <= cmd.dw_data[`ADDR_HI:`ADDR_LO];
			if (idx_r >= `DW_COL_RD_FIRST && idx_r <= `DW_COL_RD_LAST)
				col_rd_r[5'(idx_r - `DW_COL_RD_FIRST)] <= cmd.dw_data[`ADDR_HI:`ADDR_LO];
			if (idx_r == `DW_COL_WR_TOP)
				col_wr_top_r <= cmd.dw_data[`ADDR_HI:`ADDR_LO];
			if (idx_r == `DW_COL_WR_BOT)
				col_wr_bot_r <= cmd.dw_data[`ADDR_HI:`ADDR_LO];
			if (idx_r >= `DW_POC_FIRST)
				poc_r[6'(idx_r - `DW_POC_FIRST)] <= cmd.dw_data;
		end
	end

	// address arithmetic; one cycle from query to answer
	logic [31:0] slot_off;
	logic [31:0] col_off;
	logic [5:0]  poc_idx;
	cl_addr_t    col_wr_base;
	logic        col_wr_ok;

	always_comb begin
		slot_off = 32'(mb_num) * 32'(SLOT_BYTES);
		// width is fixed, so the buffer grows only with picture height
		col_off  = (32'(mb_y) * `COL_ROW_MBS + 32'(mb_x)) * `COL_MV_BYTES;
		poc_idx  = {frame_store_index[5:1], poc_bottom};
		col_wr_ok   = 1'b1;
		col_wr_base = col_rd_r[0];
		if (current_store_selector == `STORE_SEL_OWN)
			col_wr_base = bottom_field ? col_wr_bot_r : col_wr_top_r;
		else if (current_store_selector > `STORE_SEL_SHARED) begin
			col_wr_ok   = 1'b0;
			col_wr_base = '0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stream_row_addr_r   <= '0;
			mvp_row_addr_r      <= '0;
			mb_info_addr_r      <= '0;
			it_data_addr_r      <= '0;
			it_indirect_start_r <= '0;
			deblock_addr_r      <= '0;
			col_rd_addr_r       <= '0;
			col_wr_addr_r       <= '0;
			col_wr_valid_r      <= 1'b0;
			poc_value_r         <= '0;
		end else begin
			stream_row_addr_r <= {stream_row_r, 6'h00}
				+ 32'(mb_x) * (mbaff ? `STREAM_ROW_MBAFF : `STREAM_ROW_PLAIN);
			mvp_row_addr_r <= {mvp_row_r, 6'h00}
				+ 32'(mb_x) * (mbaff ? `MVP_ROW_MBAFF : `MVP_ROW_PLAIN);
			mb_info_addr_r <= {mb_info_r, 6'h00} + 32'(mb_num) * `MB_INFO_BYTES;
			it_data_addr_r <= {it_base_r, it_off_r, 6'h00} + slot_off;
			// the 4KB base belongs to the indirect base of the consumer
			it_indirect_start_r <= {20'h00000, it_off_r, 6'h00} + slot_off;
			deblock_addr_r <= {deblock_r, 6'h00} + 32'(mb_num) * `DEBLOCK_BYTES;
			col_rd_addr_r  <= {col_rd_r[col_ref_idx], 6'h00} + col_off;
			col_wr_addr_r  <= col_wr_ok ? {col_wr_base, 6'h00} + col_off : 32'h00000000;
			col_wr_valid_r <= col_wr_ok;
			// ids 0 and 1 name the current picture's two fields
			poc_value_r <= (poc_idx < `POC_ENTRIES) ? poc_r[poc_idx] : 32'h00000000;
		end
	end
endmodule // base_state_store

// ==== design/base_state_issuer.sv ====
// issuer end: software stages the payload, then the command is streamed out
// assumes one clock with the store; plain register port, read data next cycle
`timescale 1ns/1ps
`include "buf_base_defines.svh"
module base_state_issuer (
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	// register port
	input  wire logic [11:0]          addr,
	input  wire buf_base_pkg::dword_t wdata,
	input  wire logic                 wr,
	input  wire logic                 rd,
	output buf_base_pkg::dword_t      rdata_r,
	// command dwords to the store
	buf_base_if.issuer                cmd
);
	import buf_base_pkg::*;

	send_state_t tx_r;
	dw_idx_t     idx_r;
	logic        busy_r;
	logic        done_r;
	logic        dw_valid_r;
	dword_t      dw_data_r;
	dword_t      pay_r [74];
	logic        go;
	logic        sent;
	logic        pay_sel;
	dw_idx_t     pay_idx;
	logic [11:0] pay_off;

	assign cmd.dw_valid = dw_valid_r;
	assign cmd.dw_data  = dw_data_r;
	assign go      = wr && addr == `REG_CTRL && wdata[`CTRL_GO_BIT] && !busy_r;
	assign sent    = dw_valid_r && cmd.dw_ready && idx_r == `DW_POC_LAST;
	assign pay_off = addr - `REG_PAYLOAD;
	assign pay_idx = pay_off[8:2];
	// offsets past the staging window must not alias onto low dwords
	assign pay_sel = addr >= `REG_PAYLOAD && pay_off[11:9] == 3'h0 && pay_off[1:0] == 2'b00
	              && pay_idx >= `DW_STREAM_ROW && pay_idx <= `DW_POC_LAST;

	// header is built here; address dwords leave with their low bits cleared
	function automatic dword_t word_at(input dw_idx_t i, input dword_t v);
		if (i == 7'h00)
			word_at = {`HDR_TYPE_VAL, `HDR_PIPE_VAL, `HDR_OPC_VAL,
			           `HDR_SUB_VAL, `HDR_LEN_VAL};
		else if (i < `DW_POC_FIRST)
			word_at = {v[`ADDR_HI:`ADDR_LO], 6'h00};
		else
			word_at = v;
	endfunction

	// staging is not locked while busy; rewriting mid-send is the caller's hazard
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 74; i++)
				pay_r[i] <= '0;
		end else if (wr && pay_sel)
			pay_r[pay_idx] <= wdata;
	end

	// every dword goes out, all 32 read bases included
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_r       <= TX_IDLE;
			idx_r      <= '0;
			dw_valid_r <= 1'b0;
			dw_data_r  <= '0;
		end else begin
			unique case (tx_r)
				TX_IDLE: if (go) begin
					tx_r       <= TX_SEND;
					idx_r      <= '0;
					dw_valid_r <= 1'b1;
					dw_data_r  <= word_at(7'h00, 32'h00000000);
				end
				TX_SEND: if (dw_valid_r && cmd.dw_ready) begin
					if (idx_r == `DW_POC_LAST) begin
						tx_r       <= TX_IDLE;
						dw_valid_r <= 1'b0;
					end else begin
						idx_r     <= idx_r + 7'h01;
						dw_data_r <= word_at(idx_r + 7'h01, pay_r[idx_r + 7'h01]);
					end
				end
			endcase
		end
	end

	// done is sticky until the next go; the finishing event wins
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			if (go)
				busy_r <= 1'b1;
			else if (sent)
				busy_r <= 1'b0;
			if (sent)
				done_r <= 1'b1;
			else if (go)
				done_r <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			rdata_r <= '0;
		else if (rd && addr == `REG_STATUS)
			rdata_r <= {30'h0, done_r, busy_r};
		else if (rd && pay_sel)
			rdata_r <= pay_r[pay_idx];
		else
			rdata_r <= '0;
	end
endmodule // base_state_issuer

// ==== tb/buf_base_assertions.sv ====
// link checks for the buffer base state dword stream
// assumes one clock; placed beside the link that joins issuer and store
`timescale 1ns/1ps
`include "buf_base_defines.svh"
module buf_base_assertions (
	// clock and reset
	input wire logic                 clk,
	input wire logic                 rst_n,
	// dword link
	input wire logic                 dw_valid,
	input wire buf_base_pkg::dword_t dw_data,
	input wire logic                 dw_ready
);
	import buf_base_pkg::*;

	logic [6:0] pos_r;
	wire        take = dw_valid && dw_ready;

	// position of the next dword in the command, 0 is the header
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			pos_r <= 7'h00;
		else if (take)
			pos_r <= (pos_r == `DW_POC_LAST) ? 7'h00 : pos_r + 7'h01;
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_hdr;
		take && pos_r == 7'h00;
	endsequence
	sequence s_last;
		take && pos_r == `DW_POC_LAST;
	endsequence

	a_hdr_type_ok: assert property (s_hdr |-> dw_data[31:29] == 3'h3)
		else $error("header type field wrong");
	a_hdr_code_ok: assert property (s_hdr |-> dw_data[28:16] == 13'h1403)
		else $error("header pipe or opcode field wrong");
	a_hdr_len_ok: assert property (s_hdr |-> dw_data[15:0] == 16'h0048)
		else $error("header length field wrong");
	a_addr_low_zero: assert property (take && pos_r != 7'h00 && pos_r < 7'h28 |-> dw_data[5:0] == 6'h00)
		else $error("address dword low bits not zero");
	a_ready_stays: assert property (dw_ready |=> dw_ready)
		else $error("store dropped ready");
	a_payload_unbroken: assert property (take && pos_r != `DW_POC_LAST |=> dw_valid)
		else $error("gap inside a command");
	a_cmd_complete: assert property (s_hdr |-> ##73 s_last)
		else $error("command not complete after 73 beats");
	a_idle_after_last: assert property (s_last |=> !dw_valid)
		else $error("valid still high after last dword");
endmodule // buf_base_assertions

// ==== tb/test_video_decode_buffer_base_state.sv ====
// self-checking bench: issuer and store joined by one link, a second store fed bad headers
// assumes the design package, defines and link interface are compiled first
`timescale 1ns/1ps
`include "buf_base_defines.svh"
module test_video_decode_buffer_base_state;
	import buf_base_pkg::*;
	localparam int unsigned SLOT = 256;
	// indirect object base that software is taken to have set up elsewhere
	localparam logic [19:0] IND_BASE = 20'h3c5a1;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [11:0] addr = 12'h000;
	dword_t      wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	dword_t      rdata_r;
	logic [6:0]  mb_x = 7'h00;
	logic [7:0]  mb_y = 8'h00;
	logic [13:0] mb_num = 14'h0000;
	logic        mbaff = 1'b0;
	logic [4:0]  ref_i = 5'h00;
	logic [4:0]  sel = 5'h00;
	logic        bot = 1'b0;
	logic [5:0]  fsi = 6'h00;
	logic        pb = 1'b0;
	dword_t      srow, mvp, mbi, itd, ind, deb, crd, cwr, poc, srow2;
	logic        cwv, loaded, done_p, loaded2, herr2;
	dword_t      pay[74];
	dword_t      m[74];
	logic [31:0] seed = 32'h0000fd0d;
	int          n_mismatch = 0;
	int          n_compared = 0;
	int          n_load = 0;
	int          n_herr = 0;
	buf_base_if  link();
	buf_base_if  bad();

	always #20 clk = ~clk;

	base_state_issuer base_state_issuer_inst (.clk(clk), .rst_n(rst_n), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata_r(rdata_r), .cmd(link));
	base_state_store #(.SLOT_BYTES(SLOT)) base_state_store_inst (.clk(clk), .rst_n(rst_n),
		.cmd(link), .mb_x(mb_x), .mb_y(mb_y), .mb_num(mb_num), .mbaff(mbaff),
		.col_ref_idx(ref_i), .current_store_selector(sel), .bottom_field(bot),
		.frame_store_index(fsi), .poc_bottom(pb), .stream_row_addr_r(srow),
		.mvp_row_addr_r(mvp), .mb_info_addr_r(mbi), .it_data_addr_r(itd),
		.it_indirect_start_r(ind),
		.deblock_addr_r(deb), .col_rd_addr_r(crd), .col_wr_addr_r(cwr), .col_wr_valid_r(cwv),
		.poc_value_r(poc), .state_loaded_r(loaded), .load_done_r(done_p), .hdr_error_r());
	// second store: its link is driven straight from the bench with faulty headers
	base_state_store #(.SLOT_BYTES(SLOT)) base_state_store_inst2 (.clk(clk), .rst_n(rst_n),
		.cmd(bad), .mb_x(mb_x), .mb_y(mb_y), .mb_num(mb_num), .mbaff(mbaff),
		.col_ref_idx(ref_i), .current_store_selector(sel), .bottom_field(bot),
		.frame_store_index(fsi), .poc_bottom(pb), .stream_row_addr_r(srow2),
		.mvp_row_addr_r(),
		.mb_info_addr_r(), .it_data_addr_r(), .it_indirect_start_r(), .deblock_addr_r(),
		.col_rd_addr_r(), .col_wr_addr_r(), .col_wr_valid_r(), .poc_value_r(),
		.state_loaded_r(loaded2), .load_done_r(), .hdr_error_r(herr2));
	buf_base_assertions buf_base_assertions_inst (.clk(clk), .rst_n(rst_n),
		.dw_valid(link.dw_valid), .dw_data(link.dw_data), .dw_ready(link.dw_ready));

	initial begin
		bad.dw_valid = 1'b0;
		bad.dw_data = 32'h0;
	end

	always @(posedge clk) begin
		if (done_p === 1'b1)
			n_load++;
		if (herr2 === 1'b1)
			n_herr++;
	end

	function automatic dword_t rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic chk(input string nm, input dword_t exp, input dword_t got);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// write strobe is left high so back-to-back writes never touch it twice in a step
	task automatic reg_wr(input logic [11:0] a, input dword_t d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		rd <= 1'b0;
		@(posedge clk);
	endtask

	task automatic reg_rd(input logic [11:0] a, output dword_t d);
		addr <= a;
		rd <= 1'b1;
		wr <= 1'b0;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata_r;
	endtask

	task automatic qchk(input logic [4:0] s);
		dword_t r, row, x, n;
		logic [5:0] idx;
		@(posedge clk);
		r = rnd();
		mb_x <= r[6:0];
		mb_y <= r[14:7];
		mb_num <= r[28:15];
		mbaff <= r[29];
		bot <= r[30];
		pb <= r[31];
		r = rnd();
		ref_i <= r[4:0];
		fsi <= r[10:5];
		sel <= s;
		@(posedge clk);
		#1;
		x = {25'h0, mb_x};
		n = {18'h0, mb_num};
		row = ({24'h0, mb_y} * 32'h80 + x) * 32'h40;
		idx = {fsi[5:1], pb};
		chk("stream_row", m[1] + x * (mbaff ? 32'h60 : 32'h30), srow);
		chk("mvp_row", m[2] + x * (mbaff ? 32'h40 : 32'h20), mvp);
		chk("mb_info", m[3] + n * 32'h40, mbi);
		chk("it_data", {m[4][31:6], 6'h0} + n * SLOT, itd);
		chk("it_start", {20'h0, m[4][11:6], 6'h0} + n * SLOT, ind);
		chk("deblock", m[5] + n * 32'h80, deb);
		chk("col_rd", m[6 + ref_i] + row, crd);
		chk("col_wr", sel < 5'h10 ? m[6] + row : sel > 5'h10 ? 32'h0 :
			(bot ? m[39] : m[38]) + row, cwr);
		chk("col_wr_valid", sel <= 5'h10, cwv);
		chk("poc", idx < 6'h22 ? m[40 + idx] : 32'h0, poc);
	endtask

	task automatic issue();
		dword_t d;
		for (int n = 1; n < 74; n++) begin
			pay[n] = rnd();
			if (n == 4)
				pay[n][31:12] = IND_BASE;
			reg_wr(12'h100 + 12'(n * 4), pay[n]);
		end
		reg_rd(12'h114, d);
		chk("payload_rd", pay[5], d);
		reg_rd(12'h0f0, d);
		chk("unmapped_rd", 32'h0, d);
		reg_rd(12'h304, d);
		chk("alias_rd", 32'h0, d);
		qchk(5'h10);
		reg_wr(12'h000, 32'h1);
		reg_rd(12'h004, d);
		chk("status_busy", 32'h1, d);
		for (int k = 0; k < 300 && d[1] !== 1'b1; k++)
			reg_rd(12'h004, d);
		chk("status_done", 32'h2, d);
		for (int n = 1; n < 74; n++)
			m[n] = (n < 40) ? {pay[n][31:6], 6'h0} : pay[n];
	endtask

	task automatic send(input dword_t d);
		bad.dw_valid <= 1'b1;
		bad.dw_data <= d;
		@(posedge clk);
		while (bad.dw_ready !== 1'b1)
			@(posedge clk);
	endtask

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// the whole run needs under a thousand cycles; twenty thousand means a hang
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		end_sim();
	end

	initial begin
		dword_t flip[5] = '{32'h2000_0000, 32'h0800_0000, 32'h0100_0000, 32'h0001_0000,
			32'h0000_000f};
		dword_t h, st;
		foreach (m[i])
			m[i] = 32'h0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		qchk(5'h00);
		chk("state_loaded", 32'h0, loaded);
		$display("test reset values done");
		for (int c = 0; c < 2; c++) begin
			issue();
			chk("load_done_count", c + 1, n_load);
			chk("state_loaded", 32'h1, loaded);
			for (int s = 0; s < 18; s++)
				qchk(5'(s));
			$display("test command %0d done", c);
		end
		for (int f = 0; f < 5; f++) begin
			h = 32'h7403_0048 ^ flip[f];
			send(h);
			for (int k = 0; k <= int'(h[15:0]); k++)
				send(rnd());
		end
		for (int n = 0; n < 74; n++) begin
			pay[n] = (n == 0) ? 32'h7403_0048 : rnd();
			send(pay[n]);
		end
		bad.dw_valid <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk("header_errors", 32'h5, n_herr);
		chk("state_loaded2", 32'h1, loaded2);
		chk("stream_row2", {pay[1][31:6], 6'h0} + {25'h0, mb_x} * (mbaff ? 32'h60 : 32'h30),
			srow2);
		$display("test faulty headers done");
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		foreach (m[i])
			m[i] = 32'h0;
		qchk(5'h10);
		chk("state_loaded", 32'h0, loaded);
		reg_rd(12'h004, st);
		chk("status_reset", 32'h0, st);
		$display("test second reset done");
		end_sim();
	end
endmodule // test_video_decode_buffer_base_state
